/* File: hw/pmc_defines.vh */
// constants of the plc operating mode controller
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define PMC_ADR_CTRL    8'h00
`define PMC_ADR_CMD     8'h04
`define PMC_ADR_CYCLIM  8'h08
`define PMC_ADR_STATUS  8'h0C

// ***************************************************************
// field positions
// ***************************************************************
`define PMC_CTRL_RUN    0
`define PMC_CTRL_COLD   1
`define PMC_CTRL_SUBST  2
`define PMC_CTRL_BP_LO  4
`define PMC_CTRL_BP_HI  6
`define PMC_CMD_RESUME  0
`define PMC_CMD_STEP    1
`define PMC_CMD_ORESET  2
`define PMC_CMD_RELOAD  3
`define PMC_ST_MODE_LO  0
`define PMC_ST_MODE_HI  1
`define PMC_ST_INHIBIT  2
`define PMC_ST_WDOG     3
`define PMC_ST_CYCERR   4
`define PMC_ST_STEPREF  5

// ***************************************************************
// reset values, limits and encodings
// ***************************************************************
`define PMC_CTRL_RST    7'h00
`define PMC_CYCLIM_RST  16'h0096
`define PMC_CYCLIM_MIN  16'h0001
`define PMC_MODE_STOP   2'h0
`define PMC_MODE_SU     2'h1
`define PMC_MODE_RUN    2'h2
`define PMC_MODE_HOLD   2'h3
`define PMC_BP_MAX_STEP 2'h2

// ***************************************************************
// timing
// ***************************************************************
`define PMC_CLK_KHZ     40000
`define PMC_WDOG_MS     100
`define PMC_BLINK_MIN_S 3
`define PMC_BLINK_HALF_MS 250

`endif

/* File: hw/pmc_mode_ctrl.v */
// operating mode controller with wishbone register slave
`timescale 1ns/10ps
// Function
// - exactly one of four modes held: stop, start-up, run, hold
// - stop halts processing, keeps counters, timers, flags and images untouched
// - stop asserts output inhibit, disabling all digital outputs
// - leaving stop calls startup routine, which has no time supervision
// - output inhibit stays asserted throughout start-up
// - run indicator blinks at least three seconds from startup routine begin
// - stop indicator lit while startup routine runs, off afterwards
// - startup routine finished cleanly moves start-up into run
// - after watchdog error stay stopped; restart needs cold-start routine, reload or reset
// - clear input image, startup, release inhibit, cycle starts clearing output image
// - run cycles read inputs, main cycle routine, write outputs; timers active
// - run releases output inhibit so outputs follow output image
// - up to three breakpoints; reaching an active one enters hold with stepping
// - hold stops execution, freezes timers, inhibits outputs, keeps connections
// - hold blinks run indicator with stop indicator steadily lit
// - single step refused when more than two breakpoints defined
// - 100 ms watchdog and cycle supervisor from 1 ms; expiry resets into stop
// - run to stop drives analogue outputs to zero or 4 mA, or substitutes
// - overall reset erases user memory, memory card untouched
`include "pmc_defines.vh"

module pmc_mode_ctrl #(
    parameter [31:0] WDOG_CYC  = `PMC_WDOG_MS * `PMC_CLK_KHZ,
    parameter [31:0] MS_CYC    = `PMC_CLK_KHZ,
    parameter [31:0] BLINK_CYC = `PMC_BLINK_MIN_S * 1000 * `PMC_CLK_KHZ,
    parameter [31:0] HALF_CYC  = `PMC_BLINK_HALF_MS * `PMC_CLK_KHZ
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        run_sw_i,
    input  wire        phase_done_i,
    input  wire        bp_hit_i,
    output reg         clr_in_img_o,
    output reg         startup_go_o,
    output reg         clr_out_img_o,
    output reg         rd_inputs_o,
    output reg         main_go_o,
    output reg         wr_outputs_o,
    output reg         step_o,
    output reg         exec_halt_o,
    output reg         timer_freeze_o,
    output reg         cold_start_sel_o,
    output reg         output_inhibit,
    output reg         ao_safe_o,
    output reg         ao_subst_o,
    output reg         sup_reset_o,
    output reg         mem_erase_o,
    output reg         run_led_o,
    output reg         stop_led_o,
    output reg  [1:0]  mode_o
);

// ***************************************************************
// states
// ***************************************************************
localparam [7:0] S_STOP = 8'h01;
localparam [7:0] S_CLRI = 8'h02;
localparam [7:0] S_SU   = 8'h04;
localparam [7:0] S_CLRO = 8'h08;
localparam [7:0] S_RDI  = 8'h10;
localparam [7:0] S_MAIN = 8'h20;
localparam [7:0] S_WRO  = 8'h40;
localparam [7:0] S_HOLD = 8'h80;

// number of enabled breakpoints
function [1:0] bp_count;
    input [2:0] bp;
    begin
        bp_count = {1'b0, bp[0]} + {1'b0, bp[1]} + {1'b0, bp[2]};
    end
endfunction

// two-bit mode from a state
function [1:0] mode_of;
    input [7:0] s;
    begin
        if (s == S_HOLD) begin
            mode_of = `PMC_MODE_HOLD;
        end else if (s == S_CLRI || s == S_SU) begin
            mode_of = `PMC_MODE_SU;
        end else if (s == S_STOP) begin
            mode_of = `PMC_MODE_STOP;
        end else begin
            mode_of = `PMC_MODE_RUN;
        end
    end
endfunction

reg  [7:0]  state_q;
reg  [7:0]  state_d;
reg  [6:0]  ctrl_q;
reg  [15:0] cyclim_q;
reg         wdog_err_q;
reg         cyc_err_q;
reg         step_ref_q;
reg         sw_meta_q;
reg         sw_q;
reg  [31:0] wdog_cnt_q;
reg  [31:0] ms_cnt_q;
reg  [15:0] cyc_ms_q;
reg  [31:0] blink_cnt_q;
reg  [31:0] half_cnt_q;
reg         blink_ph_q;
reg         wd_fire;
reg         cyc_fire;

wire        acc     = wb_cyc_i & wb_stb_i;
wire        wr_take = acc & wb_ack_o & wb_we_i;
wire        wr_ctrl = wr_take & (wb_adr_i == `PMC_ADR_CTRL) & wb_sel_i[0];
wire        wr_cmd  = wr_take & (wb_adr_i == `PMC_ADR_CMD) & wb_sel_i[0];
wire        wr_lim  = wr_take & (wb_adr_i == `PMC_ADR_CYCLIM);
wire        wr_st   = wr_take & (wb_adr_i == `PMC_ADR_STATUS) & wb_sel_i[0];
wire        cmd_res = wr_cmd & wb_dat_i[`PMC_CMD_RESUME];
wire        cmd_stp = wr_cmd & wb_dat_i[`PMC_CMD_STEP];
wire        cmd_ors = wr_cmd & wb_dat_i[`PMC_CMD_ORESET];
wire        cmd_rld = wr_cmd & wb_dat_i[`PMC_CMD_RELOAD];
wire        run_req = sw_q & ctrl_q[`PMC_CTRL_RUN];
wire        can_go  = ~wdog_err_q | ctrl_q[`PMC_CTRL_COLD];
wire [2:0]  bp_en   = ctrl_q[`PMC_CTRL_BP_HI:`PMC_CTRL_BP_LO];
wire        step_ok = bp_count(bp_en) <= `PMC_BP_MAX_STEP;
wire        in_cyc  = (state_q == S_CLRO) | (state_q == S_RDI) | (state_q == S_MAIN) | (state_q == S_WRO);
wire        fault   = wd_fire | cyc_fire;
wire [15:0] lim_wr  = {wb_sel_i[1] ? wb_dat_i[15:8] : cyclim_q[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : cyclim_q[7:0]};

// ***************************************************************
// wishbone slave
// ***************************************************************
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= acc & ~wb_ack_o;
        if (acc & ~wb_ack_o) begin
            case (wb_adr_i)
                `PMC_ADR_CTRL: begin
                    wb_dat_o <= {25'h0000000, ctrl_q};
                end
                `PMC_ADR_CYCLIM: begin
                    wb_dat_o <= {16'h0000, cyclim_q};
                end
                `PMC_ADR_STATUS: begin
                    wb_dat_o <= {26'h0000000, step_ref_q, cyc_err_q, wdog_err_q,
                                 output_inhibit, mode_o};
                end
                default: begin
                    wb_dat_o <= 32'h00000000;
                end
            endcase
        end
    end
end

// ***************************************************************
// registers
// ***************************************************************
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl_q     <= `PMC_CTRL_RST;
        cyclim_q   <= `PMC_CYCLIM_RST;
        wdog_err_q <= 1'b0;
        cyc_err_q  <= 1'b0;
        step_ref_q <= 1'b0;
    end else begin
        if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[6:0];
        end
        if (wr_lim) begin
            cyclim_q <= (lim_wr < `PMC_CYCLIM_MIN) ? `PMC_CYCLIM_MIN : lim_wr;
        end
        if (wd_fire) begin
            wdog_err_q <= 1'b1;
        end else if (cmd_ors | cmd_rld | (state_q == S_SU && phase_done_i)) begin
            wdog_err_q <= 1'b0;
        end
        if (cyc_fire) begin
            cyc_err_q <= 1'b1;
        end else if (wr_st & wb_dat_i[`PMC_ST_CYCERR]) begin
            cyc_err_q <= 1'b0;
        end
        if (cmd_stp & (state_q == S_HOLD) & ~step_ok) begin
            step_ref_q <= 1'b1;
        end else if (wr_st & wb_dat_i[`PMC_ST_STEPREF]) begin
            step_ref_q <= 1'b0;
        end
    end
end

// ***************************************************************
// mode switch synchroniser
// ***************************************************************
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        sw_meta_q <= 1'b0;
        sw_q      <= 1'b0;
    end else begin
        sw_meta_q <= run_sw_i;
        sw_q      <= sw_meta_q;
    end
end

// ***************************************************************
// supervision
// ***************************************************************
always @* begin
    wd_fire  = in_cyc & (wdog_cnt_q >= WDOG_CYC - 32'h00000001);
    cyc_fire = in_cyc & (cyc_ms_q >= cyclim_q);
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wdog_cnt_q <= 32'h00000000;
        ms_cnt_q   <= 32'h00000000;
        cyc_ms_q   <= 16'h0000;
    end else if (~in_cyc | (state_q == S_CLRO) | (state_q == S_WRO && phase_done_i)) begin
        // startup and hold are not timed; each cycle restarts the count
        if (state_q != S_HOLD) begin
            wdog_cnt_q <= 32'h00000000;
            ms_cnt_q   <= 32'h00000000;
            cyc_ms_q   <= 16'h0000;
        end
    end else begin
        wdog_cnt_q <= wdog_cnt_q + 32'h00000001;
        if (ms_cnt_q >= MS_CYC - 32'h00000001) begin
            ms_cnt_q <= 32'h00000000;
            cyc_ms_q <= cyc_ms_q + 16'h0001;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
        end
    end
end

// ***************************************************************
// mode sequencer
// ***************************************************************
always @* begin
    state_d = state_q;
    case (state_q)
        S_STOP: begin
            if (run_req & can_go) begin
                state_d = S_CLRI;
            end
        end
        S_CLRI: begin
            if (phase_done_i) begin
                state_d = S_SU;
            end
        end
        S_SU: begin
            if (phase_done_i) begin
                state_d = S_CLRO;
            end
        end
        S_CLRO: begin
            if (phase_done_i) begin
                state_d = S_RDI;
            end
        end
        S_RDI: begin
            if (phase_done_i) begin
                state_d = S_MAIN;
            end
        end
        S_MAIN: begin
            if (bp_hit_i & (bp_en != 3'h0)) begin
                state_d = S_HOLD;
            end else if (phase_done_i) begin
                state_d = S_WRO;
            end
        end
        S_WRO: begin
            if (phase_done_i) begin
                state_d = S_RDI;
            end
        end
        S_HOLD: begin
            if (cmd_res) begin
                state_d = S_MAIN;
            end
        end
        default: begin
            state_d = S_STOP;
        end
    endcase
    if (~run_req | fault | cmd_ors) begin
        state_d = S_STOP;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        state_q        <= S_STOP;
        mode_o         <= `PMC_MODE_STOP;
        clr_in_img_o   <= 1'b0;
        startup_go_o   <= 1'b0;
        clr_out_img_o  <= 1'b0;
        rd_inputs_o    <= 1'b0;
        main_go_o      <= 1'b0;
        wr_outputs_o   <= 1'b0;
        step_o         <= 1'b0;
        exec_halt_o    <= 1'b1;
        timer_freeze_o <= 1'b1;
        output_inhibit <= 1'b1;
        ao_safe_o      <= 1'b1;
        ao_subst_o     <= 1'b0;
        sup_reset_o    <= 1'b0;
        mem_erase_o    <= 1'b0;
        cold_start_sel_o <= 1'b0;
    end else begin
        state_q        <= state_d;
        mode_o         <= mode_of(state_d);
        // one-cycle phase requests on entry, resume re-enters main
        clr_in_img_o   <= (state_d == S_CLRI) & (state_q != S_CLRI);
        startup_go_o   <= (state_d == S_SU) & (state_q != S_SU);
        clr_out_img_o  <= (state_d == S_CLRO) & (state_q != S_CLRO);
        rd_inputs_o    <= (state_d == S_RDI) & (state_q != S_RDI);
        main_go_o      <= (state_d == S_MAIN) & (state_q != S_MAIN);
        wr_outputs_o   <= (state_d == S_WRO) & (state_q != S_WRO);
        step_o         <= cmd_stp & (state_q == S_HOLD) & step_ok;
        // stop and hold halt code, contents stay as they are
        exec_halt_o    <= (state_d == S_STOP) | (state_d == S_HOLD);
        timer_freeze_o <= (state_d == S_STOP) | (state_d == S_HOLD);
        output_inhibit <= (state_d == S_STOP) | (state_d == S_CLRI) | (state_d == S_SU)
                          | (state_d == S_HOLD);
        ao_safe_o      <= (state_d == S_STOP) | (state_d == S_CLRI) | (state_d == S_SU)
                          | (state_d == S_HOLD);
        ao_subst_o     <= ctrl_q[`PMC_CTRL_SUBST];
        sup_reset_o    <= fault;
        mem_erase_o    <= cmd_ors;
        cold_start_sel_o <= wdog_err_q | wd_fire;
    end
end

// ***************************************************************
// indicators
// ***************************************************************
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        blink_cnt_q <= 32'h00000000;
        half_cnt_q  <= 32'h00000000;
        blink_ph_q  <= 1'b0;
    end else begin
        if (state_d == S_SU && state_q != S_SU) begin
            blink_cnt_q <= BLINK_CYC;
        end else if (blink_cnt_q != 32'h00000000) begin
            blink_cnt_q <= blink_cnt_q - 32'h00000001;
        end
        if (half_cnt_q >= HALF_CYC - 32'h00000001) begin
            half_cnt_q <= 32'h00000000;
            blink_ph_q <= ~blink_ph_q;
        end else begin
            half_cnt_q <= half_cnt_q + 32'h00000001;
        end
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        run_led_o  <= 1'b0;
        stop_led_o <= 1'b1;
    end else begin
        if ((blink_cnt_q != 32'h00000000) | (state_d == S_HOLD)) begin
            run_led_o <= blink_ph_q;
        end else begin
            run_led_o <= (mode_of(state_d) == `PMC_MODE_RUN);
        end
        stop_led_o <= (state_d == S_STOP) | (state_d == S_CLRI) | (state_d == S_SU)
                      | (state_d == S_HOLD);
    end
end

endmodule

/* File: verif/pmc_checker.sv */
// assertion checker for the operating mode controller
`timescale 1ns/10ps
`include "pmc_defines.vh"
module pmc_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       wb_ack_o,
    input wire logic       clr_in_img_o,
    input wire logic       startup_go_o,
    input wire logic       clr_out_img_o,
    input wire logic       step_o,
    input wire logic       exec_halt_o,
    input wire logic       timer_freeze_o,
    input wire logic       output_inhibit,
    input wire logic       ao_safe_o,
    input wire logic       sup_reset_o,
    input wire logic       mem_erase_o,
    input wire logic       stop_led_o,
    input wire logic [1:0] mode_o
);
    // ***********************
    // mode and output checks
    // ***********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_stop_safe: assert property (mode_o == `PMC_MODE_STOP |->
        output_inhibit && stop_led_o && exec_halt_o && timer_freeze_o && ao_safe_o) else $error("stop outputs wrong");
    a_su_inhibit: assert property (mode_o == `PMC_MODE_SU |->
        output_inhibit && stop_led_o) else $error("start-up outputs wrong");
    a_run_release: assert property (mode_o == `PMC_MODE_RUN |->
        !output_inhibit && !stop_led_o && !exec_halt_o) else $error("run outputs wrong");
    a_hold_frozen: assert property (mode_o == `PMC_MODE_HOLD |->
        output_inhibit && stop_led_o && exec_halt_o && timer_freeze_o) else $error("hold outputs wrong");
    a_enter_clear: assert property (mode_o == `PMC_MODE_SU && $past(mode_o) == `PMC_MODE_STOP |->
        clr_in_img_o) else $error("start-up without input image clear");
    a_startup_in_su: assert property (startup_go_o |-> mode_o == `PMC_MODE_SU)
        else $error("startup routine outside start-up");
    a_outimg_first: assert property (clr_out_img_o |->
        mode_o == `PMC_MODE_RUN && !output_inhibit && $past(mode_o) == `PMC_MODE_SU) else $error("bad run entry");
    a_step_hold: assert property (step_o |-> mode_o == `PMC_MODE_HOLD)
        else $error("step outside hold");
    a_sup_stop: assert property (sup_reset_o |-> ##[0:1] mode_o == `PMC_MODE_STOP)
        else $error("supervision fault without stop");
    a_erase_stop: assert property (mem_erase_o |-> ##[0:1] mode_o == `PMC_MODE_STOP)
        else $error("erase outside stop");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_hold: cover property (mode_o == `PMC_MODE_HOLD);
    c_step: cover property (step_o);
    c_sup: cover property (sup_reset_o);
    c_erase: cover property (mem_erase_o);
endmodule

bind pmc_mode_ctrl pmc_checker u_chk (
    .clk, .rst_b, .wb_ack_o, .clr_in_img_o, .startup_go_o, .clr_out_img_o, .step_o, .exec_halt_o,
    .timer_freeze_o, .output_inhibit, .ao_safe_o, .sup_reset_o, .mem_erase_o, .stop_led_o, .mode_o
);

/* File: verif/pmc_exec_model.sv */
// program executor model answering phase start pulses
`timescale 1ns/10ps
module pmc_exec_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       starts,
    input  wire logic       in_main,
    input  wire logic [3:0] dly,
    input  wire logic       stall,
    input  wire logic       bp_arm,
    output logic            phase_done,
    output logic            bp_hit
);
    logic       pend_q;
    logic       main_q;
    logic [3:0] cnt_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            main_q <= 1'b0;
            cnt_q <= 4'h0;
            phase_done <= 1'b0;
            bp_hit <= 1'b0;
        end else begin
            phase_done <= 1'b0;
            bp_hit <= 1'b0;
            if (starts) begin
                pend_q <= 1'b1;
                main_q <= in_main;
                cnt_q <= dly;
            end else if (pend_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (pend_q && !stall) begin
                pend_q <= 1'b0;
                bp_hit <= main_q && bp_arm;
                phase_done <= !(main_q && bp_arm);
            end
        end
    end
endmodule

/* File: verif/pmc_mode_ctrl_tb.sv */
// self-checking bench for the operating mode controller
`timescale 1ns/10ps
`include "pmc_defines.vh"
module pmc_mode_ctrl_tb;
    logic        clk, rst_b, cyc, stb, we, run_sw, stall, bp_arm, step_seen, erase_seen;
    logic [7:0]  adr;
    logic [31:0] wdat, q;
    logic [3:0]  dly;
    integer      bad_count, n_compared, k;
    wire  [31:0] rdat;
    wire  [1:0]  mode;
    wire         ack, done, bp_hit, c_in, su_go, c_out, rd_in, m_go, wr_out, step, halt, frz, cold;
    wire         inhibit, ao_safe, ao_subst, sup_rst, erase, run_led, stop_led;
    pmc_mode_ctrl #(.WDOG_CYC(200), .MS_CYC(10), .BLINK_CYC(300), .HALF_CYC(20)) uut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .run_sw_i(run_sw),
        .phase_done_i(done), .bp_hit_i(bp_hit), .clr_in_img_o(c_in), .startup_go_o(su_go),
        .clr_out_img_o(c_out), .rd_inputs_o(rd_in), .main_go_o(m_go), .wr_outputs_o(wr_out), .step_o(step),
        .exec_halt_o(halt), .timer_freeze_o(frz), .cold_start_sel_o(cold), .output_inhibit(inhibit),
        .ao_safe_o(ao_safe), .ao_subst_o(ao_subst), .sup_reset_o(sup_rst), .mem_erase_o(erase),
        .run_led_o(run_led), .stop_led_o(stop_led), .mode_o(mode));
    pmc_exec_model u_exec (.clk(clk), .rst_b(rst_b), .starts(c_in | su_go | c_out | rd_in | m_go | wr_out),
        .in_main(m_go), .dly(dly), .stall(stall), .bp_arm(bp_arm), .phase_done(done), .bp_hit(bp_hit));
    // ***********************
    // shared tasks
    // ***********************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        chk("ack_idle", ack, 1'b0);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wait_mode(input logic [1:0] m, input integer lim);
        integer t;
        t = 0;
        while (mode !== m && t < lim) begin
            @(posedge clk);
            t = t + 1;
        end
        chk("mode", mode, m);
    endtask
    task toggles(input integer n);
        logic p;
        k = 0;
        p = run_led;
        repeat (n) begin
            @(posedge clk);
            if (run_led !== p) k = k + 1;
            p = run_led;
        end
    endtask
    always @(posedge clk) begin
        if (step === 1'b1) step_seen <= 1'b1;
        if (erase === 1'b1) erase_seen <= 1'b1;
    end
    // ***********************
    // scenarios
    // ***********************
    task t_reset;
        chk("mode0", mode, `PMC_MODE_STOP);
        chk("leds0", {inhibit, run_led, stop_led}, 3'h5);
        wb(0, `PMC_ADR_CTRL, 32'h0);
        chk("ctrl", q, 32'h0);
        wb(0, 8'h10, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(0, `PMC_ADR_CYCLIM, 32'h0);
        chk("cyclim", q, 32'h96);
        wb(1, `PMC_ADR_CYCLIM, 32'h0);
        wb(0, `PMC_ADR_CYCLIM, 32'h0);
        chk("cyclim_min", q, 32'h1);
        wb(1, `PMC_ADR_CYCLIM, 32'h96);
    endtask
    task t_run;
        run_sw <= 1'b1;
        wb(1, `PMC_ADR_CTRL, 32'h1);
        wait_mode(`PMC_MODE_SU, 20);
        chk("su", {inhibit, stop_led}, 2'h3);
        wait_mode(`PMC_MODE_RUN, 40);
        chk("run_inh", inhibit, 1'b0);
        toggles(60);
        chk("blink", k != 0, 1'b1);
        repeat (300) @(posedge clk);
        toggles(60);
        chk("steady", {k != 0, run_led, stop_led}, 3'h2);
    endtask
    task t_hold;
        dly <= 4'h5;
        wb(1, `PMC_ADR_CTRL, 32'h11);
        bp_arm <= 1'b1;
        wait_mode(`PMC_MODE_HOLD, 100);
        chk("hold", {inhibit, stop_led, frz, halt}, 4'hF);
        toggles(60);
        chk("hold_blink", k != 0, 1'b1);
        step_seen <= 1'b0;
        wb(1, `PMC_ADR_CMD, 32'h2);
        repeat (4) @(posedge clk);
        chk("step", step_seen, 1'b1);
        wb(1, `PMC_ADR_CTRL, 32'h71);
        step_seen <= 1'b0;
        wb(1, `PMC_ADR_CMD, 32'h2);
        repeat (4) @(posedge clk);
        chk("no_step", step_seen, 1'b0);
        wb(0, `PMC_ADR_STATUS, 32'h0);
        chk("status", q[5:0], 6'h27);
        wb(1, `PMC_ADR_STATUS, 32'h20);
        bp_arm <= 1'b0;
        wb(1, `PMC_ADR_CTRL, 32'h1);
        wb(1, `PMC_ADR_CMD, 32'h1);
        wait_mode(`PMC_MODE_RUN, 40);
        dly <= 4'h1;
    endtask
    task t_wdog;
        stall <= 1'b1;
        wait_mode(`PMC_MODE_STOP, 400);
        wb(0, `PMC_ADR_STATUS, 32'h0);
        chk("wdog_err", q[4:3], 2'h1);
        stall <= 1'b0;
        repeat (30) @(posedge clk);
        chk("stay_stop", mode, `PMC_MODE_STOP);
        wb(1, `PMC_ADR_CTRL, 32'h3);
        wait_mode(`PMC_MODE_SU, 20);
        chk("cold", cold, 1'b1);
        stall <= 1'b1;
        repeat (300) @(posedge clk);
        chk("su_untimed", mode, `PMC_MODE_SU);
        stall <= 1'b0;
        wait_mode(`PMC_MODE_RUN, 60);
    endtask
    task t_cyc;
        wb(1, `PMC_ADR_CYCLIM, 32'h0);
        stall <= 1'b1;
        wait_mode(`PMC_MODE_STOP, 100);
        wb(0, `PMC_ADR_STATUS, 32'h0);
        chk("cyc_err", q[4], 1'b1);
        stall <= 1'b0;
        wb(1, `PMC_ADR_CYCLIM, 32'h96);
        wb(1, `PMC_ADR_STATUS, 32'h10);
        wait_mode(`PMC_MODE_RUN, 100);
    endtask
    task t_stop;
        wb(1, `PMC_ADR_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        chk("subst", ao_subst, 1'b1);
        run_sw <= 1'b0;
        wait_mode(`PMC_MODE_STOP, 10);
        chk("safe", {inhibit, ao_safe, halt, stop_led}, 4'hF);
        erase_seen <= 1'b0;
        wb(1, `PMC_ADR_CMD, 32'h4);
        repeat (4) @(posedge clk);
        chk("erase", {erase_seen, mode}, 3'h4);
    endtask
    task close_out;
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_b, cyc, stb, we, run_sw, stall, bp_arm, step_seen, erase_seen} = 9'h0;
        adr = 8'h0;
        wdat = 32'h0;
        dly = 4'h1;
        bad_count = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_run;
        t_hold;
        t_wdog;
        t_cyc;
        t_stop;
        close_out;
    end
    initial begin
        #500000;
        bad_count = bad_count + 1;
        close_out;
    end
endmodule
